// file: src/iwg_pkg.sv
package iwg_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_OFFSET_LOW  = 8'h80;
  localparam logic [7:0] OFS_OFFSET_HIGH = 8'h81;
  localparam logic [7:0] OFS_XS_LOW      = 8'h84;
  localparam logic [7:0] OFS_XS_HIGH     = 8'h85;
  localparam logic [7:0] OFS_YS_LOW      = 8'h88;
  localparam logic [7:0] OFS_YS_HIGH     = 8'h89;
  localparam logic [7:0] OFS_XE_LOW      = 8'h8c;
  localparam logic [7:0] OFS_XE_HIGH     = 8'h8d;
  localparam logic [7:0] OFS_YE_LOW      = 8'h90;
  localparam logic [7:0] OFS_YE_HIGH     = 8'h91;
  localparam logic [7:0] OFS_MISC        = 8'ha0;
  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int         MISC_VND_BIT    = 7;
  localparam int         MISC_PSAVE_BIT  = 0;
  localparam logic [9:0] POS_RESET       = 10'h000;
  localparam logic [9:0] OFFSET_RESET    = 10'h000;
  localparam logic       PSAVE_RESET     = 1'b1;
  // ----------------------------------------
  // rotation and colour depth
  // ----------------------------------------
  typedef enum logic [1:0] {
    IWG_ROT_0, IWG_ROT_90, IWG_ROT_180, IWG_ROT_270
  } iwg_rot_t;
  localparam logic [2:0] BPP_1  = 3'h0;
  localparam logic [2:0] BPP_2  = 3'h1;
  localparam logic [2:0] BPP_4  = 3'h2;
  localparam logic [2:0] BPP_8  = 3'h3;
  localparam logic [2:0] BPP_16 = 3'h4;
  localparam logic [5:0] STEP_1  = 6'h20;
  localparam logic [5:0] STEP_2  = 6'h10;
  localparam logic [5:0] STEP_4  = 6'h08;
  localparam logic [5:0] STEP_8  = 6'h04;
  localparam logic [5:0] STEP_16 = 6'h02;
  localparam logic [5:0] STEP_LINE = 6'h01;
endpackage

// file: src/iwg_step_decode.sv
`timescale 1ns/1ps
module iwg_step_decode (
  input  wire logic [1:0] rot_sel,
  input  wire logic [2:0] bpp_sel,
  output logic      [5:0] x_step,
  output logic      [5:0] y_step,
  output logic            bpp_valid
);
  function automatic logic [5:0] pix_step(input logic [2:0] b);
    case (b)
      iwg_pkg::BPP_1:  pix_step = iwg_pkg::STEP_1;
      iwg_pkg::BPP_2:  pix_step = iwg_pkg::STEP_2;
      iwg_pkg::BPP_4:  pix_step = iwg_pkg::STEP_4;
      iwg_pkg::BPP_8:  pix_step = iwg_pkg::STEP_8;
      iwg_pkg::BPP_16: pix_step = iwg_pkg::STEP_16;
      default:         pix_step = 6'h00;
    endcase
  endfunction

  logic sideways;
  // 01 and 11 select the quarter-turn orientations
  assign sideways = rot_sel[0]; // (R16)

  always_comb begin
    bpp_valid = (bpp_sel <= iwg_pkg::BPP_16); // (R17)
    if (sideways) begin
      x_step = iwg_pkg::STEP_LINE; // (R5)
      y_step = pix_step(bpp_sel); // (R7)
    end else begin
      x_step = pix_step(bpp_sel); // (R4)
      y_step = iwg_pkg::STEP_LINE; // (R6)
    end
  end
endmodule

// file: src/iwg_pos_field.sv
`timescale 1ns/1ps
module iwg_pos_field #(
  parameter logic [7:0] LOW_OFS  = 8'h84,
  parameter logic [7:0] HIGH_OFS = 8'h85
) (
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       wr_en,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       apply,
  output logic      [9:0] shadow_r,
  output logic      [9:0] active_r
);
  // ----------------------------------------
  // shadow written by software
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      shadow_r <= iwg_pkg::POS_RESET;
    end else if (wr_en && addr == LOW_OFS) begin
      shadow_r[7:0] <= wdata; // (R10)
    end else if (wr_en && addr == HIGH_OFS) begin
      shadow_r[9:8] <= wdata[1:0]; // (R10)
    end
  end

  // ----------------------------------------
  // active copy used by the display
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      active_r <= iwg_pkg::POS_RESET;
    end else if (apply) begin
      active_r <= shadow_r; // (R13)
    end
  end
endmodule

// file: src/iwg_regs.sv
`timescale 1ns/1ps
// Contract
// (R1) hold a 10-bit inset line offset in double-words
// (R2) geometry has no display effect while inset enable is clear
// (R3) x start is 10 bits from panel origin; horizontal at 0/180 only
// (R4) at 0/180 x units step 32/16/8/4/2 pixels by depth
// (R5) at 90/270 x units step one line
// (R6) at 0/180 y units step one line
// (R7) at 90/270 y units step 32/16/8/4/2 pixels by depth
// (R8) x end is 10 bits, stepped like x start
// (R9) y start and end are 10 bits; vertical at 0/180 only
// (R10) low byte holds bits 7-0, next byte bits 1-0 hold 9-8
// (R11) software keeps horizontal extent within 1024 pixels
// (R12) software keeps vertical extent within 1024 pixels
// (R13) positions apply after y-end high write, at next non-display start
// (R14) misc bit 7 reads 1 in vertical non-display, 0 in display
// (R15) inset shares main window colour depth and rotation
// (R16) rotation 00/01/10/11 is 0/90/180/270 degrees
// (R17) depth codes 000..100 are 1..16 bpp, rest reserved
module iwg_regs (
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       reg_cs,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       vert_non_display,
  input  wire logic       inset_window_enable,
  input  wire logic [1:0] rot_sel,
  input  wire logic [2:0] bpp_sel,
  output logic      [9:0] inset_line_offset,
  output logic      [9:0] inset_x_start,
  output logic      [9:0] inset_x_end,
  output logic      [9:0] inset_y_start,
  output logic      [9:0] inset_y_end,
  output logic      [5:0] inset_x_step,
  output logic      [5:0] inset_y_step,
  output logic            inset_active,
  output logic            power_save_en
);
  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic       wr_en;
  logic [9:0] offset_r;
  logic       psave_r;
  logic       pending_r;
  logic       vnd_d_r;
  logic       vnd_rise;
  logic       apply;
  logic       bpp_valid;
  logic [9:0] xs_sh, xe_sh, ys_sh, ye_sh;
  logic [9:0] xs_act, xe_act, ys_act, ye_act;
  logic [5:0] x_step_c;
  logic [5:0] y_step_c;
  logic       active_c;

  assign wr_en = reg_cs && reg_wr;

  // ----------------------------------------
  // line offset and misc control
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      offset_r <= iwg_pkg::OFFSET_RESET;
    end else if (wr_en && reg_addr == iwg_pkg::OFS_OFFSET_LOW) begin
      offset_r[7:0] <= reg_wdata; // (R1)
    end else if (wr_en && reg_addr == iwg_pkg::OFS_OFFSET_HIGH) begin
      offset_r[9:8] <= reg_wdata[1:0]; // (R1)
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      psave_r <= iwg_pkg::PSAVE_RESET;
    end else if (wr_en && reg_addr == iwg_pkg::OFS_MISC) begin
      psave_r <= reg_wdata[iwg_pkg::MISC_PSAVE_BIT];
    end
  end

  // ----------------------------------------
  // deferred apply of positions
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      vnd_d_r <= 1'b0;
    end else begin
      vnd_d_r <= vert_non_display;
    end
  end

  assign vnd_rise = vert_non_display && !vnd_d_r;
  // a write to y-end high may coincide with the edge; it then waits a frame
  assign apply    = pending_r && vnd_rise; // (R13)

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pending_r <= 1'b0;
    end else if (wr_en && reg_addr == iwg_pkg::OFS_YE_HIGH) begin
      pending_r <= 1'b1; // (R13)
    end else if (apply) begin
      pending_r <= 1'b0;
    end
  end

  iwg_pos_field #(.LOW_OFS(iwg_pkg::OFS_XS_LOW), .HIGH_OFS(iwg_pkg::OFS_XS_HIGH)) u_xs (
    .clock    (clock),
    .rst_b    (rst_b),
    .wr_en    (wr_en),
    .addr     (reg_addr),
    .wdata    (reg_wdata),
    .apply    (apply),
    .shadow_r (xs_sh),
    .active_r (xs_act)
  ); // (R3)
  iwg_pos_field #(.LOW_OFS(iwg_pkg::OFS_XE_LOW), .HIGH_OFS(iwg_pkg::OFS_XE_HIGH)) u_xe (
    .clock    (clock),
    .rst_b    (rst_b),
    .wr_en    (wr_en),
    .addr     (reg_addr),
    .wdata    (reg_wdata),
    .apply    (apply),
    .shadow_r (xe_sh),
    .active_r (xe_act)
  ); // (R8)
  iwg_pos_field #(.LOW_OFS(iwg_pkg::OFS_YS_LOW), .HIGH_OFS(iwg_pkg::OFS_YS_HIGH)) u_ys (
    .clock    (clock),
    .rst_b    (rst_b),
    .wr_en    (wr_en),
    .addr     (reg_addr),
    .wdata    (reg_wdata),
    .apply    (apply),
    .shadow_r (ys_sh),
    .active_r (ys_act)
  ); // (R9)
  iwg_pos_field #(.LOW_OFS(iwg_pkg::OFS_YE_LOW), .HIGH_OFS(iwg_pkg::OFS_YE_HIGH)) u_ye (
    .clock    (clock),
    .rst_b    (rst_b),
    .wr_en    (wr_en),
    .addr     (reg_addr),
    .wdata    (reg_wdata),
    .apply    (apply),
    .shadow_r (ye_sh),
    .active_r (ye_act)
  ); // (R9)

  // ----------------------------------------
  // stepping from shared main window settings
  // ----------------------------------------
  iwg_step_decode u_step (
    .rot_sel   (rot_sel),
    .bpp_sel   (bpp_sel),
    .x_step    (x_step_c),
    .y_step    (y_step_c),
    .bpp_valid (bpp_valid)
  ); // (R15)

  // ----------------------------------------
  // outputs to display fetch
  // ----------------------------------------
  assign active_c      = inset_window_enable && bpp_valid; // (R2)
  assign power_save_en = psave_r;

  // offset and positions gated so the display sees zeros while the window is off, steps ungated;
  // registered, so every output lags its inputs by one cycle
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      inset_active      <= 1'b0;
      inset_line_offset <= iwg_pkg::OFFSET_RESET;
      inset_x_start     <= iwg_pkg::POS_RESET;
      inset_x_end       <= iwg_pkg::POS_RESET;
      inset_y_start     <= iwg_pkg::POS_RESET;
      inset_y_end       <= iwg_pkg::POS_RESET;
      inset_x_step      <= 6'h00;
      inset_y_step      <= 6'h00;
    end else begin
      inset_active      <= active_c; // (R2)
      inset_line_offset <= active_c ? offset_r : 10'h000; // (R2)
      inset_x_start     <= active_c ? xs_act : 10'h000; // (R2)
      inset_x_end       <= active_c ? xe_act : 10'h000; // (R2)
      inset_y_start     <= active_c ? ys_act : 10'h000; // (R2)
      inset_y_end       <= active_c ? ye_act : 10'h000; // (R2)
      inset_x_step      <= x_step_c; // (R15)
      inset_y_step      <= y_step_c; // (R15)
    end
  end

  // ----------------------------------------
  // read mux; reads show shadow values
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_cs && reg_rd) begin
      case (reg_addr)
        iwg_pkg::OFS_OFFSET_LOW:  reg_rdata <= offset_r[7:0];
        iwg_pkg::OFS_OFFSET_HIGH: reg_rdata <= {6'h00, offset_r[9:8]};
        iwg_pkg::OFS_XS_LOW:      reg_rdata <= xs_sh[7:0];
        iwg_pkg::OFS_XS_HIGH:     reg_rdata <= {6'h00, xs_sh[9:8]};
        iwg_pkg::OFS_YS_LOW:      reg_rdata <= ys_sh[7:0];
        iwg_pkg::OFS_YS_HIGH:     reg_rdata <= {6'h00, ys_sh[9:8]};
        iwg_pkg::OFS_XE_LOW:      reg_rdata <= xe_sh[7:0];
        iwg_pkg::OFS_XE_HIGH:     reg_rdata <= {6'h00, xe_sh[9:8]};
        iwg_pkg::OFS_YE_LOW:      reg_rdata <= ye_sh[7:0];
        iwg_pkg::OFS_YE_HIGH:     reg_rdata <= {6'h00, ye_sh[9:8]};
        iwg_pkg::OFS_MISC:        reg_rdata <= {vert_non_display, 6'h00, psave_r}; // (R14)
        default:                  reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule

// file: sim/iwg_regs_chk.sv
`timescale 1ns/1ps
module iwg_regs_chk (
  input wire logic       clock,
  input wire logic       rst_b,
  input wire logic       reg_cs,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       vert_non_display,
  input wire logic       inset_window_enable,
  input wire logic [1:0] rot_sel,
  input wire logic [2:0] bpp_sel,
  input wire logic [9:0] inset_line_offset,
  input wire logic [9:0] inset_x_start,
  input wire logic [9:0] inset_y_end,
  input wire logic [5:0] inset_x_step,
  input wire logic [5:0] inset_y_step,
  input wire logic       inset_active
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  x_step_depth_a: assert property (
    !rot_sel[0] && bpp_sel < 3'h5 |=> inset_x_step == (6'h20 >> $past(bpp_sel)))
    else $error("x step");
  x_step_line_a: assert property (
    rot_sel[0] |=> inset_x_step == 6'h01) else $error("x line step");
  y_step_line_a: assert property (
    !rot_sel[0] |=> inset_y_step == 6'h01) else $error("y line step");
  y_step_depth_a: assert property (
    rot_sel[0] && bpp_sel < 3'h5 |=> inset_y_step == (6'h20 >> $past(bpp_sel)))
    else $error("y step");
  off_no_effect_a: assert property (
    !inset_window_enable |=> !inset_active && inset_x_start == 10'h000
    && inset_line_offset == 10'h000 && inset_y_end == 10'h000) else $error("inset on");
  depth_valid_a: assert property (
    1'b1 |=> inset_active == ($past(inset_window_enable) && $past(bpp_sel) < 3'h5))
    else $error("active wrong");
  vnd_status_a: assert property (
    reg_cs && reg_rd && reg_addr == 8'ha0 |=> reg_rdata[7] == $past(vert_non_display))
    else $error("status bit");
  pos_deferred_a: assert property (
    $changed(inset_y_end) && $stable(inset_active) && inset_active |-> $past(vert_non_display)
    || $past(vert_non_display, 2) || $past(vert_non_display, 3)) else $error("early apply");
  offset_direct_a: assert property (
    (reg_cs && reg_wr && reg_addr == 8'h80) ##2 inset_active
    |-> inset_line_offset[7:0] == $past(reg_wdata, 2)) else $error("offset");
endmodule
bind iwg_regs iwg_regs_chk u_iwg_regs_chk (.clock(clock), .rst_b(rst_b), .reg_cs(reg_cs),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .vert_non_display(vert_non_display), .rot_sel(rot_sel),
  .inset_window_enable(inset_window_enable), .bpp_sel(bpp_sel), .inset_active(inset_active),
  .inset_line_offset(inset_line_offset), .inset_x_start(inset_x_start),
  .inset_y_end(inset_y_end), .inset_x_step(inset_x_step), .inset_y_step(inset_y_step));

// file: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic       clock = 0, rst_b = 0, reg_cs = 0, reg_wr = 0, reg_rd = 0, rd_seen = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic       vert_non_display = 0, inset_window_enable = 1, inset_active, power_save_en;
  logic [1:0] rot_sel = 2'h0;
  logic [2:0] bpp_sel = 3'h0;
  logic [9:0] offs, xs, xe, ys, ye;
  logic [9:0] pos [4];
  logic [5:0] x_step, y_step, v;
  logic [31:0] seed = 32'h124f;
  logic [7:0] expq [$];
  int         n_mismatch = 0, checks = 0, cyc = 0;
  iwg_regs u_iwg_regs (.clock(clock), .rst_b(rst_b), .reg_cs(reg_cs), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .vert_non_display(vert_non_display), .inset_window_enable(inset_window_enable),
    .rot_sel(rot_sel), .bpp_sel(bpp_sel), .inset_line_offset(offs), .inset_x_start(xs),
    .inset_x_end(xe), .inset_y_start(ys), .inset_y_end(ye), .inset_x_step(x_step),
    .inset_y_step(y_step), .inset_active(inset_active), .power_save_en(power_save_en));
  initial forever #20 clock = ~clock;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task check(input logic [39:0] got, input logic [39:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one access per call; a read leaves its expected byte in the queue
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    reg_cs = 1;
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
    if (!w) expq.push_back(d);
    @(posedge clock);
    #1;
    reg_cs = 0;
    reg_wr = 0;
    reg_rd = 0;
  endtask
  // ----------------------------------------
  // read monitor and timeout
  // ----------------------------------------
  always @(posedge clock) begin
    if (rd_seen && expq.size() > 0) check(reg_rdata, expq.pop_front());
    rd_seen <= reg_cs && reg_rd;
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_mismatch++;
      end_sim();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clock);
    #1 rst_b = 1;
    foreach (pos[i]) bus(0, 8'h84 + 8'(4 * i), 8'h00);
    bus(0, 8'h81, 8'h00);
    bus(0, 8'ha0, 8'h01);
    bus(1, 8'h82, 8'hff);
    bus(0, 8'h82, 8'h00);
    seed = lfsr(seed);
    bus(1, 8'h80, seed[7:0]);
    bus(1, 8'h81, 8'hff);
    bus(0, 8'h81, 8'h03);
    check(offs, {2'h3, seed[7:0]});
    foreach (pos[i]) begin
      seed = lfsr(seed);
      pos[i] = seed[9:0];
      bus(1, 8'h84 + 8'(4 * i), seed[7:0]);
      bus(1, 8'h85 + 8'(4 * i), seed[15:8]);
      bus(0, 8'h84 + 8'(4 * i), seed[7:0]);
      bus(0, 8'h85 + 8'(4 * i), {6'h00, seed[9:8]});
    end
    check({xs, ys, xe, ye}, 40'h0);
    vert_non_display = 1;
    repeat (4) @(posedge clock);
    #1 check({xs, ys, xe, ye}, {pos[0], pos[1], pos[2], pos[3]});
    bus(0, 8'ha0, 8'h81);
    vert_non_display = 0;
    bus(1, 8'h84, ~pos[0][7:0]);
    vert_non_display = 1;
    repeat (4) @(posedge clock);
    #1 check(xs, pos[0]);
    bus(0, 8'h84, ~pos[0][7:0]);
    vert_non_display = 0;
    bus(1, 8'ha0, 8'h80);
    bus(0, 8'ha0, 8'h00);
    check(power_save_en, 1'b0);
    for (int r = 0; r < 4; r++) begin
      for (int b = 0; b < 8; b++) begin
        @(posedge clock);
        #1;
        rot_sel = 2'(r);
        bpp_sel = 3'(b);
        v = (b < 5) ? (6'h20 >> b) : 6'h00;
        @(posedge clock);
        #1 check({x_step, y_step, inset_active}, r[0] ? {6'h01, v, b < 5}
          : {v, 6'h01, b < 5});
      end
    end
    @(posedge clock);
    #1;
    inset_window_enable = 0;
    bpp_sel = 3'h0;
    @(posedge clock);
    #1 check({inset_active, offs, xs, ye}, 31'h0);
    @(posedge clock);
    #1 rst_b = 0;
    @(posedge clock);
    #1 rst_b = 1;
    check(power_save_en, 1'b1);
    bus(0, 8'h84, 8'h00);
    repeat (3) @(posedge clock);
    end_sim();
  end
endmodule
